//--- design/alu_minus_pkg.sv
// constants and types for the minus, shift, bank and pointer execution slice
package alu_minus_pkg;

  typedef struct packed {
    logic c;
    logic z;
    logic s;
    logic v;
    logic d;
    logic h;
    logic spare;
    logic bank;
  } flags_t;

  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] arg1;
    logic [7:0] arg2;
  } instr_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_HALT = 3'b100
  } exec_state_t;

  localparam logic [7:0] BANK_ZERO_SELECT_OP = 8'h4F;
  localparam logic [7:0] BANK_ONE_SELECT_OP = 8'h5F;
  localparam logic [7:0] CARRY_FORCE_OP = 8'hDF;
  localparam logic [7:0] ARITH_RIGHT_SHIFT_OP = 8'hD0;
  localparam logic [7:0] ARITH_RIGHT_SHIFT_IND_OP = 8'hD1;
  localparam logic [7:0] NIBBLE_SWAP_OP = 8'hF0;
  localparam logic [7:0] NIBBLE_SWAP_IND_OP = 8'hF1;
  localparam logic [7:0] POINTER_LOAD_OP = 8'h31;
  localparam logic [7:0] STOP_OP = 8'h7F;
  localparam logic [3:0] MINUS_ROW = 4'h2;
  localparam logic [3:0] BORROW_MINUS_ROW = 4'h3;
  localparam logic [3:0] FORM_RR = 4'h2;
  localparam logic [3:0] FORM_RIR = 4'h3;
  localparam logic [3:0] FORM_LRR = 4'h4;
  localparam logic [3:0] FORM_LRIR = 4'h5;
  localparam logic [3:0] FORM_LRIM = 4'h6;

  localparam logic [7:0] FLAGS_ADDR = 8'hD5;
  localparam logic [7:0] PTR_LOW_ADDR = 8'hD6;
  localparam logic [7:0] PTR_HIGH_ADDR = 8'hD7;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] PTR_LOW_RESET = 8'h00;
  localparam logic [7:0] PTR_HIGH_RESET = 8'h08;
  localparam logic [7:0] RDATA_IDLE = 8'h00;

  localparam logic [3:0] CYCLES_SHORT = 4'h4;
  localparam logic [3:0] CYCLES_LONG = 4'h6;

endpackage : alu_minus_pkg

//--- design/alu_minus_shift_bank_ops.sv
// execution slice: minus, shift, swap, bank, carry, pointer load and stop
`timescale 1ns/10ps
module alu_minus_shift_bank_ops
  import alu_minus_pkg::*;
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  // instruction from the decoder
  input wire logic i_start,
  input wire instr_t i_instr,
  output logic o_busy,
  output logic o_done,
  // power control
  input wire logic i_ext_int,
  output logic o_stop_mode,
  // software register port
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // status
  output flags_t o_flags
);

  exec_state_t state;
  instr_t cur;
  logic [3:0] cnt;
  logic [7:0] ptr_low;
  logic [7:0] ptr_high;
  logic [7:0] mem [0:255];
  logic commit;
  logic [7:0] dst_a;
  logic [7:0] dst_v;
  logic [7:0] src_v;
  logic [7:0] res;
  logic wr_en;
  flags_t next_flags;

  function automatic logic is_minus_op(input logic [7:0] op);
    is_minus_op = (op[7:4] == MINUS_ROW || op[7:4] == BORROW_MINUS_ROW) &&
                  op[3:0] >= FORM_RR && op[3:0] <= FORM_LRIM;
  endfunction : is_minus_op

  // register-file view: flags and pointers live in flops, not the array
  function automatic logic [7:0] rd(input logic [7:0] a);
    if (a == FLAGS_ADDR)
      rd = o_flags;
    else if (a == PTR_LOW_ADDR)
      rd = ptr_low;
    else if (a == PTR_HIGH_ADDR)
      rd = ptr_high;
    else
      rd = mem[a];
  endfunction : rd

  // working register: r0-r7 via pointer 0, r8-r15 via pointer 1
  function automatic logic [7:0] wreg(input logic [3:0] n);
    wreg = n[3] ? {ptr_high[7:3], n[2:0]} : {ptr_low[7:3], n[2:0]};
  endfunction : wreg

  assign commit = (state == ST_RUN) && (cnt == 4'h1);

  // operand fetch
  always_comb begin
    dst_a = cur.arg1;
    src_v = cur.arg2;
    if (is_minus_op(cur.opcode)) begin
      case (cur.opcode[3:0])
        FORM_RR: begin
          dst_a = wreg(cur.arg1[7:4]);
          src_v = rd(wreg(cur.arg1[3:0]));
        end
        FORM_RIR: begin
          dst_a = wreg(cur.arg1[7:4]);
          src_v = rd(rd(wreg(cur.arg1[3:0])));
        end
        FORM_LRR: begin
          dst_a = cur.arg2;
          src_v = rd(cur.arg1);
        end
        FORM_LRIR: begin
          dst_a = cur.arg2;
          src_v = rd(rd(cur.arg1));
        end
        default: begin
          dst_a = cur.arg1;
          src_v = cur.arg2;
        end
      endcase
    end else if (cur.opcode[0]) begin
      dst_a = rd(cur.arg1);
    end
    dst_v = rd(dst_a);
  end

  // result and flag computation
  always_comb begin
    logic cin;
    logic [8:0] sum;
    logic [4:0] low;
    cin = 1'b1;
    sum = 9'h000;
    low = 5'h00;
    res = dst_v;
    wr_en = 1'b0;
    next_flags = o_flags;
    if (is_minus_op(cur.opcode)) begin
      cin = (cur.opcode[7:4] == BORROW_MINUS_ROW) ? ~o_flags.c : 1'b1;
      sum = {1'b0, dst_v} + {1'b0, ~src_v} + {8'h00, cin};
      low = {1'b0, dst_v[3:0]} + {1'b0, ~src_v[3:0]} + {4'h0, cin};
      res = sum[7:0];
      wr_en = 1'b1;
      next_flags.c = ~sum[8];
      next_flags.z = (sum[7:0] == 8'h00);
      next_flags.s = sum[7];
      next_flags.v = (dst_v[7] != src_v[7]) && (sum[7] == src_v[7]);
      next_flags.d = 1'b1;
      next_flags.h = ~low[4];
    end else begin
      case (cur.opcode)
        BANK_ZERO_SELECT_OP: next_flags.bank = 1'b0;
        BANK_ONE_SELECT_OP: next_flags.bank = 1'b1;
        CARRY_FORCE_OP: next_flags.c = 1'b1;
        ARITH_RIGHT_SHIFT_OP, ARITH_RIGHT_SHIFT_IND_OP: begin
          res = {dst_v[7], dst_v[7:1]};
          wr_en = 1'b1;
          next_flags.c = dst_v[0];
          next_flags.z = (dst_v[7:1] == 7'h00) && !dst_v[7];
          next_flags.s = dst_v[7];
          next_flags.v = 1'b0;
        end
        NIBBLE_SWAP_OP, NIBBLE_SWAP_IND_OP: begin
          res = {dst_v[3:0], dst_v[7:4]};
          wr_en = 1'b1;
          next_flags.z = (dst_v == 8'h00);
          next_flags.s = dst_v[3];
        end
        default: next_flags = o_flags;
      endcase
    end
  end

  // sequencing: instruction length and stop entry/exit
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= ST_IDLE;
      cur <= '0;
      cnt <= 4'h0;
      o_busy <= 1'b0;
      o_done <= 1'b0;
    end else if (i_clk_en) begin
      o_done <= 1'b0;
      unique case (state)
        ST_IDLE: begin
          if (i_start) begin
            cur <= i_instr;
            o_busy <= 1'b1;
            state <= ST_RUN;
            if (is_minus_op(i_instr.opcode) &&
                i_instr.opcode[3:0] != FORM_RR)
              cnt <= CYCLES_LONG - 4'h1;
            else
              cnt <= CYCLES_SHORT - 4'h1;
          end
        end
        ST_RUN: begin
          if (commit) begin
            o_done <= 1'b1;
            o_busy <= 1'b0;
            state <= (cur.opcode == STOP_OP) ? ST_HALT : ST_IDLE;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        ST_HALT: begin
          if (i_ext_int)
            state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // stop mode flag tells the clock circuit to halt cpu and system clocks
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n)
      o_stop_mode <= 1'b0;
    else if (i_clk_en) begin
      if (commit && cur.opcode == STOP_OP)
        o_stop_mode <= 1'b1;
      else if (state == ST_HALT && i_ext_int)
        o_stop_mode <= 1'b0;
    end
  end

  // register array: no reset so contents survive stop and reset alike
  always_ff @(posedge i_clock) begin
    if (i_clk_en) begin
      if (commit && wr_en)
        mem[dst_a] <= res;
      else if (i_wr)
        mem[i_addr] <= i_wdata;
    end
  end

  // flags: an executing instruction beats a software write that cycle
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n)
      o_flags <= FLAGS_RESET;
    else if (i_clk_en) begin
      if (commit)
        o_flags <= next_flags;
      else if (i_wr && i_addr == FLAGS_ADDR)
        o_flags <= i_wdata;
    end
  end

  // working window pointers
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ptr_low <= PTR_LOW_RESET;
      ptr_high <= PTR_HIGH_RESET;
    end else if (i_clk_en) begin
      if (commit && cur.opcode == POINTER_LOAD_OP) begin
        case (cur.arg1[1:0])
          2'b10: ptr_low[7:3] <= cur.arg1[7:3];
          2'b01: ptr_high[7:3] <= cur.arg1[7:3];
          2'b00: begin
            ptr_low[7:3] <= {cur.arg1[7:4], 1'b0};
            ptr_high[7:3] <= {cur.arg1[7:4], 1'b1};
          end
          default: ptr_low <= ptr_low;
        endcase
      end else if (commit && wr_en) begin
        if (dst_a == PTR_LOW_ADDR)
          ptr_low <= res;
        if (dst_a == PTR_HIGH_ADDR)
          ptr_high <= res;
      end else if (i_wr) begin
        if (i_addr == PTR_LOW_ADDR)
          ptr_low <= i_wdata;
        if (i_addr == PTR_HIGH_ADDR)
          ptr_high <= i_wdata;
      end
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n)
      o_rdata <= RDATA_IDLE;
    else if (i_clk_en)
      o_rdata <= i_rd ? rd(i_addr) : RDATA_IDLE;
  end

  // checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  logic take;
  assign take = (state == ST_IDLE) && i_start && i_clk_en;

  a_bank_zero_flags: assert property (
    commit && i_clk_en && cur.opcode == BANK_ZERO_SELECT_OP |=>
      !o_flags.bank && o_flags[7:1] == $past(o_flags[7:1]))
    else $error("bank zero select changed flags wrongly");

  a_bank_one_flags: assert property (
    commit && i_clk_en && cur.opcode == BANK_ONE_SELECT_OP |=>
      o_flags.bank && o_flags[7:1] == $past(o_flags[7:1]))
    else $error("bank one select changed flags wrongly");

  a_carry_force_only: assert property (
    commit && i_clk_en && cur.opcode == CARRY_FORCE_OP |=>
      o_flags.c && o_flags[6:0] == $past(o_flags[6:0]))
    else $error("carry force wrong");

  a_minus_d_flag: assert property (
    commit && i_clk_en && is_minus_op(cur.opcode) |=>
      o_flags.d && o_flags.v == (($past(dst_v[7]) != $past(src_v[7])) &&
      o_flags.s == $past(src_v[7])))
    else $error("minus decimal or overflow flag wrong");

  a_shift_clears_v: assert property (
    commit && i_clk_en && cur.opcode[7:1] == ARITH_RIGHT_SHIFT_OP[7:1] |=>
      !o_flags.v && o_flags.d == $past(o_flags.d) &&
      o_flags.h == $past(o_flags.h))
    else $error("shift flag update wrong");

  a_swap_keeps_flags: assert property (
    commit && i_clk_en && cur.opcode[7:1] == NIBBLE_SWAP_OP[7:1] |=>
      {o_flags.c, o_flags.v, o_flags.d, o_flags.h} ==
      $past({o_flags.c, o_flags.v, o_flags.d, o_flags.h}))
    else $error("swap disturbed kept flags");

  a_stop_entry: assert property (
    commit && i_clk_en && cur.opcode == STOP_OP |=>
      o_stop_mode && o_flags == $past(o_flags))
    else $error("stop not entered");

  a_stop_hold_state: assert property (
    o_stop_mode && !i_ext_int |=> o_stop_mode && o_flags == $past(o_flags))
    else $error("stop mode left without cause");

  a_short_latency: assert property (
    take && !is_minus_op(i_instr.opcode) ##1 i_clk_en [*3] |=> o_done)
    else $error("four cycle instruction timing wrong");

  a_long_latency: assert property (
    take && is_minus_op(i_instr.opcode) && i_instr.opcode[3:0] != FORM_RR
      ##1 (i_clk_en && !o_done) [*5] |=> o_done)
    else $error("six cycle instruction timing wrong");

  a_pointer_both: assert property (
    commit && i_clk_en && cur.opcode == POINTER_LOAD_OP &&
      cur.arg1[1:0] == 2'b00 |=>
      !ptr_low[3] && ptr_high[3] && ptr_low[7:4] == ptr_high[7:4])
    else $error("pointer pair load wrong");

  // opcode bit 4 separates the borrow row from the plain minus row
  a_minus_result: assert property (
    commit && i_clk_en && is_minus_op(cur.opcode) |=>
      mem[$past(dst_a)] == $past(dst_v) - $past(src_v) -
      {7'h00, $past(cur.opcode[4] & o_flags.c)})
    else $error("minus result wrong");

  a_minus_borrow: assert property (
    commit && i_clk_en && is_minus_op(cur.opcode) |=>
      o_flags.c == ({1'b0, $past(dst_v)} <
      {1'b0, $past(src_v)} + {8'h00, $past(cur.opcode[4] & o_flags.c)}))
    else $error("minus borrow flag wrong");

  a_minus_zero_sign: assert property (
    commit && i_clk_en && is_minus_op(cur.opcode) |=>
      o_flags.z == (mem[$past(dst_a)] == 8'h00) &&
      o_flags.s == mem[$past(dst_a)][7])
    else $error("minus zero or sign flag wrong");

  a_shift_result: assert property (
    commit && i_clk_en && cur.opcode[7:1] == ARITH_RIGHT_SHIFT_OP[7:1] |=>
      mem[$past(dst_a)] == {$past(dst_v[7]), $past(dst_v[7:1])} &&
      o_flags.c == $past(dst_v[0]))
    else $error("arithmetic shift result wrong");

  a_swap_result: assert property (
    commit && i_clk_en && cur.opcode[7:1] == NIBBLE_SWAP_OP[7:1] |=>
      mem[$past(dst_a)] == {$past(dst_v[3:0]), $past(dst_v[7:4])} &&
      o_flags.z == (mem[$past(dst_a)] == 8'h00) &&
      o_flags.s == mem[$past(dst_a)][7])
    else $error("nibble swap result wrong");

  a_pointer_single: assert property (
    commit && i_clk_en && cur.opcode == POINTER_LOAD_OP &&
      cur.arg1[1:0] == 2'b10 |=>
      ptr_low[7:3] == $past(cur.arg1[7:3]) && ptr_high == $past(ptr_high))
    else $error("single pointer load wrong");

  a_pointer_keeps_flags: assert property (
    commit && i_clk_en && cur.opcode == POINTER_LOAD_OP |=>
      o_flags == $past(o_flags))
    else $error("pointer load changed flags");

  // a frozen clock enable holds the pulse, so only enabled cycles count
  a_done_pulse: assert property (
    o_done && i_clk_en |=> !o_done)
    else $error("done held past one cycle");

  a_rdata_idle: assert property (
    !i_rd && i_clk_en |=> o_rdata == RDATA_IDLE)
    else $error("read data outside read cycle");

  c_borrow_minus: cover property (
    commit && cur.opcode[7:4] == BORROW_MINUS_ROW && o_flags.c);
  c_stop_exit: cover property (o_stop_mode ##1 !o_stop_mode);
  c_swap_indirect: cover property (commit && cur.opcode == NIBBLE_SWAP_IND_OP);
  c_pointer_load: cover property (commit && cur.opcode == POINTER_LOAD_OP);

endmodule : alu_minus_shift_bank_ops

//--- sim/alu_minus_shift_bank_ops_tb_top.sv
// self-checking bench for the minus, shift, swap, bank and pointer slice
`timescale 1ns/10ps
module alu_minus_shift_bank_ops_tb_top;
  import alu_minus_pkg::*;
  logic i_clock, i_rst_n, i_clk_en, i_start, i_ext_int, i_wr, i_rd;
  instr_t i_instr;
  logic [7:0] i_addr, i_wdata, o_rdata, pl, ph;
  logic o_busy, o_done, o_stop_mode;
  flags_t o_flags;
  int fails, num_checks, seed;
  logic [7:0] ctl_ops [4] = '{8'h4F, 8'h5F, 8'hDF, 8'h31};
  logic [7:0] un_ops [4] = '{8'hD0, 8'hD1, 8'hF0, 8'hF1};

  alu_minus_shift_bank_ops u_alu_minus_shift_bank_ops (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_clk_en(i_clk_en),
    .i_start(i_start), .i_instr(i_instr), .o_busy(o_busy),
    .o_done(o_done), .i_ext_int(i_ext_int), .o_stop_mode(o_stop_mode),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .o_flags(o_flags)
  );

  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  task end_sim;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim

  task chk(input logic [7:0] got, exp, input string m);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask : chk

  task wr(input logic [7:0] a, dt);
    @(posedge i_clock);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= dt;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask : wr

  task rc(input logic [7:0] a, exp, input string m);
    @(posedge i_clock);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1;
    chk(o_rdata, exp, m);
  endtask : rc

  // counts cycles from the take edge to the done pulse
  task exec(input logic [7:0] op, a1, a2, input logic [3:0] n);
    int k;
    @(posedge i_clock);
    i_start <= 1'b1;
    i_instr <= {op, a1, a2};
    @(posedge i_clock);
    i_start <= 1'b0;
    k = 1;
    #1;
    chk({6'h00, o_busy, o_done}, 8'h02, "busy after take");
    while (o_done !== 1'b1 && k < 20) begin
      @(posedge i_clock);
      #1;
      k++;
    end
    chk(8'(k), {4'h0, n}, "cycle count");
    chk({6'h00, o_busy, o_done}, 8'h01, "busy at done");
  endtask : exec

  function automatic logic [15:0] f_minus(input logic [7:0] d, s,
      input logic ci, input flags_t f);
    logic [7:0] r;
    r = d - s - {7'h00, ci};
    f.c = {1'b0, d} < ({1'b0, s} + {8'h00, ci});
    f.z = (r == 8'h00);
    f.s = r[7];
    f.v = (d[7] != s[7]) && (r[7] == s[7]);
    f.d = 1'b1;
    f.h = {1'b0, d[3:0]} < ({1'b0, s[3:0]} + {4'h0, ci});
    return {f, r};
  endfunction : f_minus

  function automatic logic [15:0] f_unary(input logic sw,
      input logic [7:0] v, input flags_t f);
    logic [7:0] r;
    r = sw ? {v[3:0], v[7:4]} : {v[7], v[7:1]};
    if (!sw) begin
      f.c = v[0];
      f.v = 1'b0;
    end
    f.z = (r == 8'h00);
    f.s = r[7];
    return {f, r};
  endfunction : f_unary

  task do_minus(input logic [3:0] row, fm, input logic [7:0] d, s);
    logic [7:0] rv, da, sa;
    logic [15:0] e;
    rv = $random(seed);
    da = (fm < 4) ? 8'h01 : 8'h20;
    sa = (fm < 4) ? 8'h02 : 8'h21;
    wr(da, d);
    wr(sa, (fm == 3 || fm == 5) ? 8'h30 : s);
    wr(8'h30, s);
    wr(FLAGS_ADDR, rv);
    e = f_minus(d, s, (row == BORROW_MINUS_ROW) & rv[7], flags_t'(rv));
    exec({row, fm}, (fm < 4) ? 8'h12 : ((fm == 6) ? 8'h20 : sa),
      (fm == 6) ? s : 8'h20, (fm == 2) ? CYCLES_SHORT : CYCLES_LONG);
    chk(o_flags, e[15:8], "minus flags");
    rc(da, e[7:0], "minus result");
    rc(sa, (fm == 3 || fm == 5) ? 8'h30 : s, "source kept");
    rc(8'h30, s, "indirect source kept");
  endtask : do_minus

  task do_unary(input logic [7:0] op, v);
    logic [7:0] rv, a;
    logic [15:0] e;
    rv = $random(seed);
    a = op[0] ? 8'h42 : 8'h40;
    wr(8'h41, 8'h42);
    wr(a, v);
    wr(FLAGS_ADDR, rv);
    e = f_unary(op[5], v, flags_t'(rv));
    exec(op, op[0] ? 8'h41 : 8'h40, 8'h00, CYCLES_SHORT);
    chk(o_flags, e[15:8], "unary flags");
    rc(a, e[7:0], "unary result");
    rc(8'h41, 8'h42, "pointer register kept");
  endtask : do_unary

  task do_ctl(input logic [7:0] op, imm);
    logic [7:0] rv;
    flags_t f;
    rv = $random(seed);
    f = flags_t'(rv);
    wr(FLAGS_ADDR, f);
    exec(op, imm, 8'h00, CYCLES_SHORT);
    if (op == BANK_ZERO_SELECT_OP) f.bank = 1'b0;
    if (op == BANK_ONE_SELECT_OP) f.bank = 1'b1;
    if (op == CARRY_FORCE_OP) f.c = 1'b1;
    if (op == POINTER_LOAD_OP) begin
      case (imm[1:0])
        2'h2: pl[7:3] = imm[7:3];
        2'h1: ph[7:3] = imm[7:3];
        2'h0: begin
          pl[7:3] = {imm[7:4], 1'b0};
          ph[7:3] = {imm[7:4], 1'b1};
        end
        default: ;
      endcase
    end
    chk(o_flags, f, "control flags");
    rc(PTR_LOW_ADDR, pl, "pointer low");
    rc(PTR_HIGH_ADDR, ph, "pointer high");
  endtask : do_ctl

  // run should take about 1300 cycles; allow over twenty times that (30000 cycles)
  initial begin
    #300000;
    fails++;
    $display("wrong value at %0t: run did not finish", $time);
    end_sim;
  end

  initial begin
    logic [7:0] d, s;
    int i, j, r, fm;
    seed = 55742;
    fails = 0;
    num_checks = 0;
    i_rst_n = 1'b0;
    i_clk_en = 1'b1;
    i_start = 1'b0;
    i_instr = '0;
    i_ext_int = 1'b0;
    i_addr = 8'h00;
    i_wdata = 8'h00;
    i_wr = 1'b0;
    i_rd = 1'b0;
    pl = 8'h00;
    ph = 8'h08;
    repeat (6) @(posedge i_clock);
    i_rst_n <= 1'b1;
    rc(PTR_LOW_ADDR, pl, "pointer low reset");
    rc(PTR_HIGH_ADDR, ph, "pointer high reset");
    $display("test reset done");
    for (r = 2; r < 4; r++) begin
      for (fm = 2; fm < 7; fm++) begin
        for (j = 0; j < 4; j++) begin
          d = $random(seed);
          s = $random(seed);
          if (j == 0) begin
            d = 8'h80;
            s = 8'h01;
          end
          if (j == 1) begin
            d = 8'h00;
            s = 8'hFF;
          end
          do_minus(r[3:0], fm[3:0], d, s);
        end
      end
    end
    $display("test minus done");
    for (i = 0; i < 16; i++) begin
      d = $random(seed);
      do_unary(un_ops[i % 4], (i < 4) ? 8'h00 : ((i < 8) ? 8'h81 : d));
    end
    $display("test shift and swap done");
    for (i = 0; i < 16; i++) begin
      d = $random(seed);
      do_ctl(ctl_ops[i % 4], {d[7:2], i[3:2]});
    end
    $display("test control ops done");
    // enable low for five cycles must stretch a short instruction by five
    @(posedge i_clock);
    i_start <= 1'b1;
    i_instr <= {CARRY_FORCE_OP, 16'h0000};
    @(posedge i_clock);
    i_start <= 1'b0;
    i_clk_en <= 1'b0;
    repeat (5) @(posedge i_clock);
    i_clk_en <= 1'b1;
    #1;
    chk({6'h00, o_busy, o_done}, 8'h02, "frozen by enable");
    repeat (3) @(posedge i_clock);
    #1;
    chk({6'h00, o_busy, o_done}, 8'h01, "done after enable");
    chk({7'h00, o_flags.c}, 8'h01, "carry after freeze");
    $display("test clock enable done");
    wr(FLAGS_ADDR, 8'h00);
    exec(STOP_OP, 8'h00, 8'h00, CYCLES_SHORT);
    chk({7'h00, o_stop_mode}, 8'h01, "stop entered");
    chk(o_flags, 8'h00, "stop flags");
    @(posedge i_clock);
    i_start <= 1'b1;
    i_instr <= {CARRY_FORCE_OP, 16'h0000};
    @(posedge i_clock);
    i_start <= 1'b0;
    repeat (8) @(posedge i_clock);
    #1;
    chk(o_flags, 8'h00, "start while stopped");
    rc(PTR_HIGH_ADDR, ph, "pointer retained");
    @(posedge i_clock);
    i_ext_int <= 1'b1;
    @(posedge i_clock);
    i_ext_int <= 1'b0;
    #1;
    chk({7'h00, o_stop_mode}, 8'h00, "interrupt wake");
    exec(STOP_OP, 8'h00, 8'h00, CYCLES_SHORT);
    @(posedge i_clock);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clock);
    i_rst_n <= 1'b1;
    #1;
    chk({7'h00, o_stop_mode}, 8'h00, "reset wake");
    pl = 8'h00;
    ph = 8'h08;
    rc(PTR_LOW_ADDR, pl, "pointer low after reset");
    exec(CARRY_FORCE_OP, 8'h00, 8'h00, CYCLES_SHORT);
    chk(o_flags, 8'h80, "carry forced after wake");
    $display("test stop done");
    end_sim;
  end
endmodule : alu_minus_shift_bank_ops_tb_top
